// *** usbef_pkg.sv ***
package usbef_pkg;
    // ==========================================================
    // Endpoint register map on the firmware port
    localparam logic [2:0] REG_SELECT = 3'h0;
    localparam logic [2:0] REG_FLAGS = 3'h1;
    localparam logic [2:0] REG_ENABLES = 3'h2;
    localparam logic [2:0] REG_DATA = 3'h3;
    localparam logic [2:0] REG_CNT_HIGH = 3'h4;
    localparam logic [2:0] REG_CNT_LOW = 3'h5;
    localparam logic [2:0] REG_SUMMARY = 3'h6;
    localparam logic [2:0] REG_STATUS = 3'h7;
    // ==========================================================
    // endpoint_event_flags bit positions
    localparam int FLG_FIFO_HANDOVER = 7;
    localparam int FLG_NAK_IN = 6;
    localparam int FLG_ACCESS = 5;
    localparam int FLG_NAK_OUT = 4;
    localparam int FLG_SETUP = 3;
    localparam int FLG_OUT_DISCARD = 2;
    localparam int FLG_STALL = 1;
    localparam int FLG_TX_READY = 0;
    // endpoint_event_enables bit positions
    localparam int EN_FLOW_ERROR = 7;
    localparam logic [7:0] ENABLES_WMASK = 8'hdf;
    // Status register bit positions
    localparam int STS_OVERFLOW = 7;
    localparam int STS_UNDERFLOW = 6;
    localparam int STS_FOLLOW_DIR = 2;
    localparam int STS_BANK_MSB = 1;
    // ==========================================================
    // Reset values and widths
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam int CNT_W = 11;
    localparam logic [2:0] FORBIDDEN_EP = 3'h7;
    // ==========================================================
    // Controller APB map
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_RESULT = 8'h04;
    localparam int CMD_WR_BIT = 24;
    localparam int CMD_ADDR_LSB = 16;
    localparam int RES_BUSY = 8;
    localparam int RES_REFUSED = 9;
    localparam int RES_IRQ = 10;
    typedef enum logic [0:0] {
        USBEF_IDLE = 1'b0,
        USBEF_WAIT = 1'b1
    } usbef_state_t;
endpackage

// *** usbef_if.sv ***
`timescale 1ns/1ns
interface usbef_if;
    logic req;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    logic irq;
    modport dev(input req, wr, addr, wdata, output rdata, ack, irq);
    modport fw(output req, wr, addr, wdata, input rdata, ack, irq);
endinterface

// *** usbef_host.sv ***
`timescale 1ns/1ns
module usbef_host
    import usbef_pkg::*;
(
    input wire logic clk_in, // System clock
    input wire logic sys_rst_in, // Async reset, active high
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction
    input wire logic [7:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error, unused
    output logic irq_out, // Endpoint interrupt level
    usbef_if.fw ep // Endpoint register port
);
    usbef_state_t state;
    logic refused;
    logic [7:0] result;
    logic [31:0] next_prdata;
    logic req;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;

    // ==========================================================
    // Decode
    wire logic setup_ph = psel_in && !penable_in;
    wire logic wr_take = psel_in && penable_in && pwrite_in;
    wire logic cmd_wr = wr_take && paddr_in == APB_CMD;
    wire logic [2:0] cmd_addr = pwdata_in[CMD_ADDR_LSB +: 3];
    wire logic cmd_is_wr = pwdata_in[CMD_WR_BIT];
    wire logic bad_sel = cmd_is_wr && cmd_addr == REG_SELECT
        && pwdata_in[2:0] == FORBIDDEN_EP;
    wire logic busy = state == USBEF_WAIT;

    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;
    assign irq_out = ep.irq;
    assign ep.req = req;
    assign ep.wr = wr;
    assign ep.addr = addr;
    assign ep.wdata = wdata;

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr_in == APB_RESULT) begin
            next_prdata[7:0] = result;
            next_prdata[RES_BUSY] = busy;
            next_prdata[RES_REFUSED] = refused;
            next_prdata[RES_IRQ] = ep.irq;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata_out <= next_prdata;
        end
    end

    // ==========================================================
    // Command sequencer
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= USBEF_IDLE;
            req <= 1'b0;
            wr <= 1'b0;
            addr <= 3'h0;
            wdata <= 8'h00;
            refused <= 1'b0;
            result <= 8'h00;
        end else begin
            unique case (state)
                USBEF_IDLE: begin
                    if (cmd_wr && bad_sel) begin
                        refused <= 1'b1;
                    end else if (cmd_wr) begin
                        refused <= 1'b0;
                        req <= 1'b1;
                        wr <= cmd_is_wr;
                        addr <= cmd_addr;
                        wdata <= pwdata_in[7:0];
                        state <= USBEF_WAIT;
                    end
                end
                USBEF_WAIT: begin
                    if (ep.ack) begin
                        req <= 1'b0;
                        result <= ep.rdata;
                        state <= USBEF_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// *** usbef_device.sv ***
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - SETUP records following direction, read only
// - One-bit active bank index, read only
// - OUT/SETUP store sets handover with flag
// - OUT handover clear frees bank, switches except on control
// - IN bank free sets handover, clear sends
// - NAK to IN sets flag, interrupts
// - Access allowed: IN room, OUT data
// - NAK to OUT/PING sets flag, interrupts
// - Valid SETUP sets flag, never on IN
// - Received packet sets OUT flag, interrupts
// - IN kill command discards bank, self-clears
// - STALL sent or iso CRC sets stalled
// - Free IN bank sets ready, never OUT
// - Flags clear by zero, ones ignored, except IN kill bit; access flag read only
// - Each source gated by its enable
// - Data port moves one byte per access
// - Eleven-bit count split high and low
// - Count follows pushes and pops per direction
// - Summary bit per endpoint, bit seven zero
// - Firmware never selects endpoint seven
// - Iso overflow and underflow set flow flags
module usbef_device
    import usbef_pkg::*;
#(
    parameter int NUM_EP = 7,
    parameter int DEPTH = 64
) (
    input wire logic clk_in, // System clock
    input wire logic sys_rst_in, // Async reset, also USB bus reset
    usbef_if.dev cpu, // Firmware register port
    input wire logic [2:0] ev_ep_in, // Endpoint of engine event
    input wire logic setup_in, // Valid SETUP stored
    input wire logic follow_is_in_in, // Direction after SETUP, 1 is IN
    input wire logic out_in, // OUT packet stored
    input wire logic bank_free_in, // IN bank sent, now free
    input wire logic nak_in_in, // NAK sent to IN token
    input wire logic nak_out_in, // NAK sent to OUT or PING
    input wire logic stall_in, // STALL handshake sent
    input wire logic crc_err_in, // CRC error seen
    input wire logic overflow_in, // Iso overflow
    input wire logic underflow_in, // Iso underflow
    input wire logic rx_valid_in, // Received byte strobe
    input wire logic [7:0] rx_byte_in, // Received byte
    input wire logic tx_pop_in, // Byte taken for sending
    output logic [7:0] tx_byte_out, // Byte being sent
    input wire logic [6:0] ep_is_in_in, // Endpoint direction, 1 is IN
    input wire logic [6:0] ep_iso_in, // Endpoint is isochronous
    input wire logic [6:0] ep_ctrl_in, // Endpoint is control
    input wire logic [6:0] stall_request_in // STALL requested
);
    localparam int PW = $clog2(DEPTH);

    function automatic int mem_index(input int ep_n, input int ptr);
        mem_index = ep_n * DEPTH + ptr;
    endfunction

    logic [2:0] endpoint_select;
    logic ack;
    logic [7:0] rdata;
    logic [7:0] flag_q [NUM_EP];
    logic [7:0] next_flags [NUM_EP];
    logic [7:0] flags_rd [NUM_EP];
    logic [7:0] en_q [NUM_EP];
    logic [CNT_W-1:0] fifo_byte_count [NUM_EP];
    logic [PW-1:0] wr_ptr [NUM_EP];
    logic [PW-1:0] rd_ptr [NUM_EP];
    logic [NUM_EP-1:0] active_bank_index;
    logic [NUM_EP-1:0] setup_follow_direction;
    logic [NUM_EP-1:0] iso_overflow_flag;
    logic [NUM_EP-1:0] iso_underflow_flag;
    logic [NUM_EP-1:0] push_fw;
    logic [NUM_EP-1:0] push_rx;
    logic [NUM_EP-1:0] pop_fw;
    logic [NUM_EP-1:0] pop_tx;
    logic [6:0] per_endpoint_irq_summary;
    logic [7:0] fifo_mem [NUM_EP*DEPTH];
    logic [7:0] rd_mux;

    // ==========================================================
    // Register port decode
    wire logic take = cpu.req && !ack;
    wire logic wr_take = take && cpu.wr;
    wire logic rd_take = take && !cpu.wr;
    wire logic sel_ok = int'(endpoint_select) < NUM_EP;
    wire logic [2:0] rs = sel_ok ? endpoint_select : 3'h0;
    wire logic ev_ok = int'(ev_ep_in) < NUM_EP;
    wire logic [2:0] es = ev_ok ? ev_ep_in : 3'h0;

    assign cpu.ack = ack;
    assign cpu.rdata = rdata;
    assign cpu.irq = |per_endpoint_irq_summary;

    // ==========================================================
    // Per-endpoint flags, bank and count
    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
        wire logic is_in = ep_is_in_in[e];
        wire logic hit = ev_ok && ev_ep_in == 3'(e);
        wire logic sel = sel_ok && endpoint_select == 3'(e);
        wire logic wr_flags = wr_take && cpu.addr == REG_FLAGS && sel;
        wire logic wr_status = wr_take && cpu.addr == REG_STATUS && sel;
        wire logic [7:0] keep = wr_flags ? cpu.wdata : 8'hff;
        wire logic room = fifo_byte_count[e] < CNT_W'(DEPTH);
        wire logic filled = fifo_byte_count[e] != '0;
        wire logic set_out = hit && out_in && !is_in;
        wire logic set_setup = hit && setup_in && !is_in;
        wire logic set_free = hit && bank_free_in && is_in;
        wire logic set_stall = hit && (stall_in
            || (crc_err_in && ep_iso_in[e] && !is_in));
        wire logic kill = is_in && flag_q[e][FLG_OUT_DISCARD];
        wire logic released = wr_flags && flag_q[e][FLG_FIFO_HANDOVER]
            && !cpu.wdata[FLG_FIFO_HANDOVER];
        wire logic flow_err = iso_overflow_flag[e] | iso_underflow_flag[e];
        wire logic access_allowed_flag = (is_in ? room : filled)
            && !stall_request_in[e] && !flow_err && !ep_ctrl_in[e];
        wire logic [7:0] src = {flow_err, flags_rd[e][6], 1'b0,
            flags_rd[e][4:3], flags_rd[e][2] & !is_in, flags_rd[e][1:0]};

        assign push_fw[e] = wr_take && cpu.addr == REG_DATA && sel
            && is_in && room;
        assign pop_fw[e] = rd_take && cpu.addr == REG_DATA && sel
            && !is_in && filled;
        assign push_rx[e] = hit && rx_valid_in && !is_in && room;
        assign pop_tx[e] = hit && tx_pop_in && is_in && filled;

        assign next_flags[e][FLG_FIFO_HANDOVER] =
            (flag_q[e][FLG_FIFO_HANDOVER] & keep[FLG_FIFO_HANDOVER])
            | set_out | set_setup | set_free;
        assign next_flags[e][FLG_NAK_IN] = (flag_q[e][FLG_NAK_IN]
            & keep[FLG_NAK_IN]) | (hit && nak_in_in);
        assign next_flags[e][FLG_ACCESS] = 1'b0;
        assign next_flags[e][FLG_NAK_OUT] = (flag_q[e][FLG_NAK_OUT]
            & keep[FLG_NAK_OUT]) | (hit && nak_out_in);
        assign next_flags[e][FLG_SETUP] = ((flag_q[e][FLG_SETUP]
            & keep[FLG_SETUP]) | set_setup) & !is_in;
        assign next_flags[e][FLG_OUT_DISCARD] = is_in
            ? wr_flags && cpu.wdata[FLG_OUT_DISCARD]
            : (flag_q[e][FLG_OUT_DISCARD] & keep[FLG_OUT_DISCARD])
              | set_out;
        assign next_flags[e][FLG_STALL] = (flag_q[e][FLG_STALL]
            & keep[FLG_STALL]) | set_stall;
        assign next_flags[e][FLG_TX_READY] = ((flag_q[e][FLG_TX_READY]
            & keep[FLG_TX_READY]) | set_free) & is_in;

        assign flags_rd[e] = {flag_q[e][7:6], access_allowed_flag,
            flag_q[e][4:0]};
        assign per_endpoint_irq_summary[e] = |(src & en_q[e]);

        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                flag_q[e] <= FLAGS_RESET;
                en_q[e] <= ENABLES_RESET;
                active_bank_index[e] <= 1'b0;
                setup_follow_direction[e] <= 1'b0;
                iso_overflow_flag[e] <= 1'b0;
                iso_underflow_flag[e] <= 1'b0;
            end else begin
                flag_q[e] <= next_flags[e];
                if (wr_take && cpu.addr == REG_ENABLES && sel) begin
                    en_q[e] <= cpu.wdata & ENABLES_WMASK;
                end
                if (released && !ep_ctrl_in[e]) begin
                    active_bank_index[e] <= !active_bank_index[e];
                end
                if (set_setup) begin
                    setup_follow_direction[e] <= follow_is_in_in;
                end
                iso_overflow_flag[e] <= (iso_overflow_flag[e]
                    & !(wr_status && !cpu.wdata[STS_OVERFLOW]))
                    | (hit && overflow_in && ep_iso_in[e]);
                iso_underflow_flag[e] <= (iso_underflow_flag[e]
                    & !(wr_status && !cpu.wdata[STS_UNDERFLOW]))
                    | (hit && underflow_in && ep_iso_in[e]);
            end
        end

        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                fifo_byte_count[e] <= '0;
                wr_ptr[e] <= '0;
                rd_ptr[e] <= '0;
            end else if (kill) begin
                // Whole backlog goes, also when pointers meet at full
                fifo_byte_count[e] <= '0;
                wr_ptr[e] <= rd_ptr[e];
            end else begin
                fifo_byte_count[e] <= fifo_byte_count[e]
                    + CNT_W'(push_fw[e] | push_rx[e])
                    - CNT_W'(pop_fw[e] | pop_tx[e]);
                wr_ptr[e] <= wr_ptr[e] + PW'(push_fw[e] | push_rx[e]);
                rd_ptr[e] <= rd_ptr[e] + PW'(pop_fw[e] | pop_tx[e]);
            end
        end
    end

    // ==========================================================
    // FIFO storage
    always_ff @(posedge clk_in) begin
        if (|push_fw) begin
            fifo_mem[mem_index(int'(rs), int'(wr_ptr[rs]))] <= cpu.wdata;
        end
        if (|push_rx) begin
            fifo_mem[mem_index(int'(es), int'(wr_ptr[es]))] <= rx_byte_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_byte_out <= 8'h00;
        end else if (|pop_tx) begin
            tx_byte_out <= fifo_mem[mem_index(int'(es), int'(rd_ptr[es]))];
        end
    end

    // ==========================================================
    // Read selection
    always_comb begin
        rd_mux = 8'h00;
        if (sel_ok || cpu.addr == REG_SELECT || cpu.addr == REG_SUMMARY) begin
            unique case (cpu.addr)
                REG_SELECT: rd_mux = {5'h00, endpoint_select};
                REG_FLAGS: rd_mux = flags_rd[rs];
                REG_ENABLES: rd_mux = en_q[rs];
                REG_DATA: rd_mux = fifo_mem[mem_index(int'(rs),
                    int'(rd_ptr[rs]))];
                REG_CNT_HIGH: rd_mux = {5'h00, fifo_byte_count[rs][10:8]};
                REG_CNT_LOW: rd_mux = fifo_byte_count[rs][7:0];
                REG_SUMMARY: rd_mux = {1'b0, per_endpoint_irq_summary};
                REG_STATUS: rd_mux = {iso_overflow_flag[rs],
                    iso_underflow_flag[rs], 3'h0,
                    setup_follow_direction[rs], 1'b0,
                    active_bank_index[rs]};
            endcase
        end
    end

    // ==========================================================
    // Register port: answer one cycle after the request is taken
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack <= 1'b0;
            rdata <= 8'h00;
            endpoint_select <= SELECT_RESET;
        end else begin
            ack <= take;
            if (rd_take) begin
                rdata <= rd_mux;
            end
            if (wr_take && cpu.addr == REG_SELECT) begin
                endpoint_select <= cpu.wdata[2:0];
            end
        end
    end
endmodule

// *** usbef_chk.sv ***
`timescale 1ns/1ns
module usbef_chk
    import usbef_pkg::*;
(
    input wire logic clk_in, // System clock
    input wire logic sys_rst_in, // Async reset
    input wire logic req_in, // Access request
    input wire logic wr_in, // Direction
    input wire logic [2:0] addr_in, // Register index
    input wire logic [7:0] wdata_in, // Write data
    input wire logic [7:0] rdata_in, // Read data
    input wire logic ack_in, // Answer pulse
    input wire logic irq_in // Endpoint interrupt
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ==========================================================
    // Taken requests
    wire take = req_in && !ack_in;
    wire rd_sum = take && !wr_in && addr_in == REG_SUMMARY;
    wire rd_en = take && !wr_in && addr_in == REG_ENABLES;
    wire rd_cnth = take && !wr_in && addr_in == REG_CNT_HIGH;
    wire rd_sts = take && !wr_in && addr_in == REG_STATUS;
    // ==========================================================
    // Handshake and read-back checks
    a_ack_follows: assert property (take |=> ack_in)
        else $error("ack missing after request");
    a_ack_pulse: assert property (ack_in |=> !ack_in)
        else $error("ack longer than one cycle");
    a_no_stray: assert property (!req_in |=> !ack_in)
        else $error("ack without request");
    a_req_released: assert property (ack_in |=> !req_in)
        else $error("request held past ack");
    a_req_held: assert property (take |=> $stable(addr_in) && $stable(wr_in)
        && $stable(wdata_in))
        else $error("request changed before ack");
    a_sum_top: assert property (rd_sum |=> !rdata_in[7])
        else $error("summary bit 7 set");
    a_en_reserved: assert property (rd_en |=> !rdata_in[5])
        else $error("enable bit 5 set");
    a_cnt_high: assert property (rd_cnth |=> rdata_in[7:3] == 5'h0)
        else $error("count high upper bits set");
    a_bank_code: assert property (rd_sts |=> !rdata_in[1])
        else $error("reserved bank code");
    a_irq_summary: assert property (rd_sum |=>
        irq_in == |rdata_in[6:0])
        else $error("irq differs from summary");
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top
    import usbef_pkg::*;
;
    logic clk_in, sys_rst_in, psel, penable, pwrite, pready, pslverr;
    logic irq_out, follow;
    logic [7:0] paddr, rx_byte, tx_byte, r;
    logic [31:0] pwdata, prdata, res;
    logic [2:0] ev_ep;
    logic [10:0] evs;
    logic [6:0] ep_is_in, ep_iso, ep_ctrl, stall_rq;
    int n_fail, cmp_count;
    usbef_if bus();
    usbef_host i_usbef_host(.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq_out),
        .ep(bus));
    usbef_device i_usbef_device(.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .cpu(bus), .ev_ep_in(ev_ep), .setup_in(evs[0]),
        .follow_is_in_in(follow), .out_in(evs[1]), .bank_free_in(evs[2]),
        .nak_in_in(evs[3]), .nak_out_in(evs[4]), .stall_in(evs[5]),
        .crc_err_in(evs[6]), .overflow_in(evs[7]), .underflow_in(evs[8]),
        .rx_valid_in(evs[9]), .rx_byte_in(rx_byte), .tx_pop_in(evs[10]),
        .tx_byte_out(tx_byte), .ep_is_in_in(ep_is_in), .ep_iso_in(ep_iso),
        .ep_ctrl_in(ep_ctrl), .stall_request_in(stall_rq));
    usbef_chk i_usbef_chk(.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .req_in(bus.req), .wr_in(bus.wr), .addr_in(bus.addr),
        .wdata_in(bus.wdata), .rdata_in(bus.rdata), .ack_in(bus.ack),
        .irq_in(bus.irq));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        res = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic ep_op(input logic w, input logic [2:0] i,
        input logic [7:0] d);
        logic [31:0] c;
        c = 32'h0;
        c[CMD_WR_BIT] = w;
        c[CMD_ADDR_LSB +: 3] = i;
        c[7:0] = d;
        apb(1'b1, APB_CMD, c);
        res = 32'h100;
        while (res[RES_BUSY] !== 1'b0) begin
            apb(1'b0, APB_RESULT, 32'h0);
        end
        r = res[7:0];
    endtask
    task automatic rd_chk(input logic [2:0] i, input logic [7:0] m,
        input logic [7:0] exp);
        ep_op(1'b0, i, 8'h00);
        chk(r & m, exp);
    endtask
    task automatic fire(input logic [2:0] ep, input int k);
        ev_ep <= ep;
        evs <= 11'h1 << k;
        @(posedge clk_in);
        evs <= 11'h0;
        @(posedge clk_in);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic reset_values;
        rd_chk(REG_FLAGS, 8'hff, FLAGS_RESET);
        rd_chk(REG_SUMMARY, 8'hff, 8'h00);
        rd_chk(REG_CNT_LOW, 8'hff, 8'h00);
        ep_op(1'b1, REG_ENABLES, 8'hff);
        rd_chk(REG_ENABLES, 8'hff, ENABLES_WMASK);
        ep_op(1'b1, REG_ENABLES, ENABLES_RESET);
        ep_op(1'b1, REG_SELECT, 8'h07);
        chk({7'h0, res[RES_REFUSED]}, 8'h01);
    endtask
    task automatic out_path;
        ep_op(1'b1, REG_SELECT, 8'h01);
        ep_op(1'b1, REG_ENABLES, 8'h04);
        for (int i = 0; i < 3; i++) begin
            rx_byte <= 8'h30 + 8'(i);
            fire(3'h1, 9);
        end
        rd_chk(REG_CNT_LOW, 8'hff, 8'h03);
        rd_chk(REG_CNT_HIGH, 8'hff, 8'h00);
        fire(3'h1, 1);
        rd_chk(REG_FLAGS, 8'hff, 8'ha4);
        rd_chk(REG_SUMMARY, 8'hff, 8'h02);
        chk({7'h0, irq_out}, 8'h01);
        chk({7'h0, res[RES_IRQ]}, 8'h01);
        rd_chk(REG_DATA, 8'hff, 8'h30);
        rd_chk(REG_CNT_LOW, 8'hff, 8'h02);
        ep_op(1'b1, REG_FLAGS, 8'hff);
        rd_chk(REG_FLAGS, 8'hff, 8'ha4);
        ep_op(1'b1, REG_FLAGS, 8'ha0);
        rd_chk(REG_SUMMARY, 8'hff, 8'h00);
        ep_op(1'b1, REG_FLAGS, 8'h20);
        rd_chk(REG_STATUS, 8'h03, 8'h01);
        stall_rq <= 7'h02;
        rd_chk(REG_FLAGS, 8'hff, 8'h00);
        stall_rq <= 7'h00;
    endtask
    task automatic in_path;
        ep_op(1'b1, REG_SELECT, 8'h02);
        ep_op(1'b1, REG_DATA, 8'h11);
        ep_op(1'b1, REG_DATA, 8'h22);
        rd_chk(REG_CNT_LOW, 8'hff, 8'h02);
        fire(3'h2, 10);
        rd_chk(REG_CNT_LOW, 8'hff, 8'h01);
        chk(tx_byte, 8'h11);
        fire(3'h2, 2);
        rd_chk(REG_FLAGS, 8'hff, 8'ha1);
        ep_op(1'b1, REG_FLAGS, 8'ha5);
        rd_chk(REG_CNT_LOW, 8'hff, 8'h00);
        rd_chk(REG_FLAGS, 8'h04, 8'h00);
        fire(3'h2, 0);
        rd_chk(REG_FLAGS, 8'h08, 8'h00);
        ep_op(1'b1, REG_FLAGS, 8'h00);
        rd_chk(REG_STATUS, 8'h03, 8'h01);
        for (int i = 0; i < 65; i++) begin
            ep_op(1'b1, REG_DATA, 8'(i));
        end
        rd_chk(REG_CNT_LOW, 8'hff, 8'h40);
        ep_op(1'b1, REG_FLAGS, 8'h04);
        rd_chk(REG_CNT_LOW, 8'hff, 8'h00);
    endtask
    task automatic mid_reset;
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        ep_op(1'b1, REG_SELECT, 8'h01);
        rd_chk(REG_CNT_LOW, 8'hff, 8'h00);
        rd_chk(REG_STATUS, 8'hff, 8'h00);
        ep_op(1'b1, REG_FLAGS, 8'hff);
        rd_chk(REG_FLAGS, 8'hff, 8'h00);
    endtask
    task automatic event_table;
        int ks[5] = '{3, 4, 5, 6, 0};
        logic [7:0] bs[5] = '{8'h40, 8'h10, 8'h02, 8'h02, 8'h08};
        follow <= 1'b1;
        ep_op(1'b1, REG_SELECT, 8'h03);
        foreach (ks[i]) begin
            fire(3'h3, ks[i]);
            rd_chk(REG_FLAGS, bs[i], bs[i]);
            ep_op(1'b1, REG_FLAGS, 8'h00);
            rd_chk(REG_FLAGS, bs[i], 8'h00);
        end
        ep_op(1'b1, REG_STATUS, 8'h00);
        rd_chk(REG_STATUS, 8'h04, 8'h04);
        ep_op(1'b1, REG_ENABLES, 8'h80);
        fire(3'h3, 7);
        rd_chk(REG_STATUS, 8'h80, 8'h80);
        rd_chk(REG_SUMMARY, 8'hff, 8'h08);
        ep_op(1'b1, REG_STATUS, 8'h00);
        rd_chk(REG_SUMMARY, 8'hff, 8'h00);
        fire(3'h3, 8);
        rd_chk(REG_STATUS, 8'h40, 8'h40);
    endtask
    // ==========================================================
    // Clock, sequence and watchdog
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        complete_run();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, follow} = '0;
        {ev_ep, evs, rx_byte, stall_rq} = '0;
        n_fail = 0;
        cmp_count = 0;
        ep_is_in = 7'h04;
        ep_ctrl = 7'h01;
        ep_iso = 7'h08;
        sys_rst_in = 1'b1;
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        reset_values();
        out_path();
        in_path();
        event_table();
        mid_reset();
        complete_run();
    end
endmodule
